// [ipr_pkg.sv]
package ipr_pkg;

  // source identifier codes, one per reporting peripheral
  typedef enum logic [4:0] {
    SYSTEM_CONTROLLER_SOURCE = 5'h00,
    ANALOGUE_BLOCK_SOURCE    = 5'h01,
    SERIAL_PORT0_SOURCE      = 5'h02,
    SERIAL_PORT1_SOURCE      = 5'h03,
    TIMER0_SOURCE            = 5'h04,
    TIMER1_SOURCE            = 5'h05,
    TIMER2_SOURCE            = 5'h06,
    TIMER3_SOURCE            = 5'h07,
    TIMER4_SOURCE            = 5'h08,
    TIMER5_SOURCE            = 5'h09,
    TIMER6_SOURCE            = 5'h0a,
    TIMER7_SOURCE            = 5'h0b,
    TIMER8_SOURCE            = 5'h0c,
    TICK_TIMER_SOURCE        = 5'h0d,
    TWO_WIRE_SOURCE          = 5'h0e,
    SERIAL_MASTER_SOURCE     = 5'h0f,
    SERIAL_SLAVE_SOURCE      = 5'h10,
    FLASH_ERROR_SOURCE       = 5'h11,
    INFRARED_SOURCE          = 5'h12,
    CIPHER_ENGINE_SOURCE     = 5'h13
  } ipr_source_t;

  // report sequencer states
  typedef enum logic [1:0] {
    IPR_SCAN = 2'b01,
    IPR_HOLD = 2'b10
  } ipr_state_t;

  localparam int NUM_SOURCES = 20;
  localparam int NUM_TIMERS = 9;
  localparam int NUM_IO_LINES = 20;
  localparam int CAUSE_WIDTH = 32;
  localparam int SERIAL_CODE_WIDTH = 3;
  localparam int FIRST_TIMER_INDEX = 4;
  localparam int SERIAL_PORT0_INDEX = 2;
  localparam int SERIAL_PORT1_INDEX = 3;

  // system controller cause bit positions
  localparam int CLOCK_SWITCH_BIT = 31;
  localparam int RANDOM_VALUE_BIT = 30;
  localparam int COMPARATOR1_BIT = 29;
  localparam int COMPARATOR0_BIT = 28;
  localparam int WAKE_TIMER1_BIT = 27;
  localparam int WAKE_TIMER0_BIT = 26;
  localparam int BROWNOUT_ENTER_BIT = 25;
  localparam int BROWNOUT_EXIT_BIT = 24;
  localparam int PULSE_COUNTER1_BIT = 23;
  localparam int PULSE_COUNTER0_BIT = 22;
  localparam int IO_LINE0_BIT = 0;

  // analogue block cause bit positions
  localparam int ADC_BUFFER_OVERFLOW_BIT = 4;
  localparam int ADC_BUFFER_FULL_BIT = 3;
  localparam int ADC_BUFFER_HALF_BIT = 2;
  localparam int ADC_ACCUMULATED_READY_BIT = 1;
  localparam int ADC_SAMPLE_READY_BIT = 0;

  // timer, tick, infrared and single-event bit positions
  localparam int TIMER_RISING_BIT = 1;
  localparam int TIMER_PERIOD_END_BIT = 0;
  localparam int TICK_BIT = 0;
  localparam int INFRARED_DONE_BIT = 0;
  localparam int SINGLE_EVENT_BIT = 0;

  // two-wire bus cause masks
  localparam logic [31:0] MASTER_TRANSFER_DONE_MASK = 32'h0000_0001;
  localparam logic [31:0] ARBITRATION_LOST_MASK = 32'h0000_0002;
  localparam logic [31:0] MASTER_NO_ACK_MASK = 32'h0000_0004;
  localparam logic [31:0] SLAVE_TX_STOP_SEEN_MASK = 32'h0000_0008;
  localparam logic [31:0] TWO_WIRE_BUS_ERROR_MASK = 32'h0000_0040;
  localparam logic [31:0] MASTER_TX_DATA_REQUEST_MASK = 32'h0000_0080;
  localparam logic [31:0] SLAVE_TX_DATA_REQUEST_MASK = 32'h0000_0100;

  // reset values
  localparam logic [31:0] CAUSE_RESET = 32'h0000_0000;
  localparam logic [4:0] SOURCE_RESET = 5'h00;

endpackage

// [ipr_cause_latch.sv]
`timescale 1ns/1ps
module ipr_cause_latch
  import ipr_pkg::*;
#(
  parameter int WIDTH = 32
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [WIDTH-1:0] setBits,
  input wire logic [WIDTH-1:0] clearBits,
  input wire logic enable,
  output logic [WIDTH-1:0] pending,
  output logic request
);

  logic [WIDTH-1:0] pending_q;

  // sticky bits; a set in the same cycle as its clear survives
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pending_q <= '0;
    end else begin
      pending_q <= (pending_q & ~clearBits) | setBits;
    end
  end

  assign pending = pending_q;
  // request is a level that stays up while anything enabled is pending
  assign request = enable & (|pending_q);

endmodule

// [ipr_edge_detect.sv]
`timescale 1ns/1ps
module ipr_edge_detect
  import ipr_pkg::*;
#(
  parameter int WIDTH = 9
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rising,
  output logic [WIDTH-1:0] falling
);

  logic [WIDTH-1:0] prev_q;

  // inputs come from logic on this clock, so no synchroniser is needed
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prev_q <= '0;
    end else begin
      prev_q <= level;
    end
  end

  // a level already high at reset release shows as one rising edge
  assign rising = level & ~prev_q;
  assign falling = ~level & prev_q;

endmodule

// [ipr_cause_report.sv]
`timescale 1ns/1ps
// Summary of operation
// [RULE_01] every report names its source peripheral
// [RULE_02] report carries a 32-bit cause word
// [RULE_03] serial ports report an enumerated code instead
// [RULE_04] system bit 31 marks clock source switch
// [RULE_05] system bit 30 marks new random value
// [RULE_06] bits 29..26: comparators, then wake timers
// [RULE_07] bit 25 brownout entered, bit 24 exited
// [RULE_08] bits 23, 22: pulse counters hit reference
// [RULE_09] io line events sit at their line number
// [RULE_10] adc buffer overflow, full, half: bits 4..2
// [RULE_11] bit 1 accumulated sample, accumulation mode only
// [RULE_12] bit 0 single conversion done, every mode
// [RULE_13] timer bit 1 on enabled rising output
// [RULE_14] timer bit 0 on enabled period end
// [RULE_15] tick timer always reports bit 0
// [RULE_16] infrared bit 0 on transmission done
// [RULE_17] mask 0x0001 master transfer done, master only
// [RULE_18] mask 0x0002 arbitration lost, either role
// [RULE_19] mask 0x0004 master transmitter got no ack
// [RULE_20] mask 0x0008 slave transmitter saw stop
// [RULE_21] mask 0x0040 two-wire bus error
// [RULE_22] data request: 0x0080 master, 0x0100 slave
// [RULE_23] causes stick until serviced; request holds meanwhile
module ipr_cause_report
  import ipr_pkg::*;
#(
  parameter int TIMERS = NUM_TIMERS,
  parameter int IO_LINES = NUM_IO_LINES
) (
  input wire logic clock,
  input wire logic rst,
  // system controller events, one-cycle pulses
  input wire logic clockSwitchEvent,
  input wire logic randomValueEvent,
  input wire logic comparator1Event,
  input wire logic comparator0Event,
  input wire logic wakeTimer1Event,
  input wire logic wakeTimer0Event,
  input wire logic brownoutEnterEvent,
  input wire logic brownoutExitEvent,
  input wire logic pulseCounter1Event,
  input wire logic pulseCounter0Event,
  input wire logic [IO_LINES-1:0] ioLineEvent,
  // analogue block events
  input wire logic adcBufferOverflowEvent,
  input wire logic adcBufferFullEvent,
  input wire logic adcBufferHalfEvent,
  input wire logic adcAccumulatedReadyEvent,
  input wire logic adcSampleReadyEvent,
  input wire logic adcAccumulateMode,
  // general timers
  input wire logic [TIMERS-1:0] timerOutput,
  input wire logic [TIMERS-1:0] timerRisingIntEnable,
  input wire logic [TIMERS-1:0] timerPeriodIntEnable,
  // tick timer and infrared
  input wire logic tickEvent,
  input wire logic infraredDoneEvent,
  // two-wire bus
  input wire logic twoWireMasterMode,
  input wire logic masterTransferDone,
  input wire logic arbitrationLost,
  input wire logic masterNoAck,
  input wire logic slaveTxStopSeen,
  input wire logic twoWireBusError,
  input wire logic txDataRequest,
  // serial master and slave raw cause pulses
  input wire logic [CAUSE_WIDTH-1:0] serialMasterEvents,
  input wire logic [CAUSE_WIDTH-1:0] serialSlaveEvents,
  // flash error and cipher engine
  input wire logic flashErrorEvent,
  input wire logic cipherDoneEvent,
  // serial ports keep their own request level and reason code
  input wire logic serialPort0Request,
  input wire logic [SERIAL_CODE_WIDTH-1:0] serialPort0Code,
  input wire logic serialPort1Request,
  input wire logic [SERIAL_CODE_WIDTH-1:0] serialPort1Code,
  // per-source enables and service handshake
  input wire logic [NUM_SOURCES-1:0] sourceEnable,
  input wire logic reportAck,
  output logic reportValid,
  output ipr_source_t sourceIdentifier,
  output logic [CAUSE_WIDTH-1:0] causeWord,
  output logic [NUM_SOURCES-1:0] sourceRequest,
  output logic interruptRequest
);

  logic [CAUSE_WIDTH-1:0] setVec [NUM_SOURCES];
  logic [CAUSE_WIDTH-1:0] clearVec [NUM_SOURCES];
  logic [CAUSE_WIDTH-1:0] pendingVec [NUM_SOURCES];
  logic [TIMERS-1:0] timerRise;
  logic [TIMERS-1:0] timerFall;
  logic [CAUSE_WIDTH-1:0] systemSet;
  logic [CAUSE_WIDTH-1:0] analogueSet;
  logic [CAUSE_WIDTH-1:0] twoWireSet;
  logic pickFound;
  ipr_source_t pickSource;
  logic [4:0] pickIndex;
  ipr_state_t state_q;
  ipr_state_t state_d;
  ipr_source_t sourceId_q;
  logic [CAUSE_WIDTH-1:0] cause_q;
  logic serviceDone;

  // timer output edges, gated later by each timer's own enables
  ipr_edge_detect #(
    .WIDTH(TIMERS)
  ) u_timer_edges (
    .clock(clock),
    .rst(rst),
    .level(timerOutput),
    .rising(timerRise),
    .falling(timerFall)
  );

  // system controller cause word assembly
  always_comb begin
    systemSet = CAUSE_RESET;
    systemSet[CLOCK_SWITCH_BIT] = clockSwitchEvent; // [RULE_04]
    systemSet[RANDOM_VALUE_BIT] = randomValueEvent; // [RULE_05]
    systemSet[COMPARATOR1_BIT] = comparator1Event; // [RULE_06]
    systemSet[COMPARATOR0_BIT] = comparator0Event; // [RULE_06]
    systemSet[WAKE_TIMER1_BIT] = wakeTimer1Event; // [RULE_06]
    systemSet[WAKE_TIMER0_BIT] = wakeTimer0Event; // [RULE_06]
    systemSet[BROWNOUT_ENTER_BIT] = brownoutEnterEvent; // [RULE_07]
    systemSet[BROWNOUT_EXIT_BIT] = brownoutExitEvent; // [RULE_07]
    systemSet[PULSE_COUNTER1_BIT] = pulseCounter1Event; // [RULE_08]
    systemSet[PULSE_COUNTER0_BIT] = pulseCounter0Event; // [RULE_08]
    systemSet[IO_LINE0_BIT +: IO_LINES] = ioLineEvent; // [RULE_09]
  end

  // analogue block; the accumulated flag means nothing outside accumulation
  always_comb begin
    analogueSet = CAUSE_RESET;
    analogueSet[ADC_BUFFER_OVERFLOW_BIT] = adcBufferOverflowEvent; // [RULE_10]
    analogueSet[ADC_BUFFER_FULL_BIT] = adcBufferFullEvent; // [RULE_10]
    analogueSet[ADC_BUFFER_HALF_BIT] = adcBufferHalfEvent; // [RULE_10]
    analogueSet[ADC_ACCUMULATED_READY_BIT] = adcAccumulatedReadyEvent
        & adcAccumulateMode; // [RULE_11]
    analogueSet[ADC_SAMPLE_READY_BIT] = adcSampleReadyEvent; // [RULE_12]
  end

  // two-wire bus; role-specific causes are filtered by the current role
  always_comb begin
    twoWireSet = CAUSE_RESET;
    if (twoWireMasterMode) begin
      if (masterTransferDone) begin
        twoWireSet = twoWireSet | MASTER_TRANSFER_DONE_MASK; // [RULE_17]
      end
      if (masterNoAck) begin
        twoWireSet = twoWireSet | MASTER_NO_ACK_MASK; // [RULE_19]
      end
      if (txDataRequest) begin
        twoWireSet = twoWireSet | MASTER_TX_DATA_REQUEST_MASK; // [RULE_22]
      end
    end else begin
      if (slaveTxStopSeen) begin
        twoWireSet = twoWireSet | SLAVE_TX_STOP_SEEN_MASK; // [RULE_20]
      end
      if (txDataRequest) begin
        twoWireSet = twoWireSet | SLAVE_TX_DATA_REQUEST_MASK; // [RULE_22]
      end
    end
    if (arbitrationLost) begin
      twoWireSet = twoWireSet | ARBITRATION_LOST_MASK; // [RULE_18]
    end
    if (twoWireBusError) begin
      twoWireSet = twoWireSet | TWO_WIRE_BUS_ERROR_MASK; // [RULE_21]
    end
  end

  // route every source's set pulses into its own slot
  always_comb begin
    for (int s = 0; s < NUM_SOURCES; s++) begin
      setVec[s] = CAUSE_RESET;
    end
    setVec[SYSTEM_CONTROLLER_SOURCE] = systemSet;
    setVec[ANALOGUE_BLOCK_SOURCE] = analogueSet;
    for (int t = 0; t < TIMERS; t++) begin
      setVec[FIRST_TIMER_INDEX + t][TIMER_RISING_BIT] =
          timerRise[t] & timerRisingIntEnable[t]; // [RULE_13]
      setVec[FIRST_TIMER_INDEX + t][TIMER_PERIOD_END_BIT] =
          timerFall[t] & timerPeriodIntEnable[t]; // [RULE_14]
    end
    setVec[TICK_TIMER_SOURCE][TICK_BIT] = tickEvent; // [RULE_15]
    setVec[TWO_WIRE_SOURCE] = twoWireSet;
    setVec[SERIAL_MASTER_SOURCE] = serialMasterEvents;
    setVec[SERIAL_SLAVE_SOURCE] = serialSlaveEvents;
    setVec[FLASH_ERROR_SOURCE][SINGLE_EVENT_BIT] = flashErrorEvent;
    setVec[INFRARED_SOURCE][INFRARED_DONE_BIT] = infraredDoneEvent; // [RULE_16]
    setVec[CIPHER_ENGINE_SOURCE][SINGLE_EVENT_BIT] = cipherDoneEvent;
  end

  // service clears exactly the bits it was shown, later arrivals stay
  assign serviceDone = (state_q == IPR_HOLD) & reportAck;

  // one sticky latch per bitmap source, serial ports pass their code through
  for (genvar g = 0; g < NUM_SOURCES; g++) begin : g_source
    if (g == SERIAL_PORT0_INDEX || g == SERIAL_PORT1_INDEX) begin : g_code
      logic req;
      logic [SERIAL_CODE_WIDTH-1:0] code;
      assign req = (g == SERIAL_PORT0_INDEX) ? serialPort0Request : serialPort1Request;
      assign code = (g == SERIAL_PORT0_INDEX) ? serialPort0Code : serialPort1Code;
      // the port drops its own request once its reason is dealt with
      assign pendingVec[g] = {{(CAUSE_WIDTH - SERIAL_CODE_WIDTH){1'b0}}, code}; // [RULE_03]
      assign sourceRequest[g] = req & sourceEnable[g];
      assign clearVec[g] = CAUSE_RESET;
    end else begin : g_bits
      assign clearVec[g] = (serviceDone && sourceId_q == ipr_source_t'(g)) ?
          cause_q : CAUSE_RESET;
      ipr_cause_latch #(
        .WIDTH(CAUSE_WIDTH)
      ) u_latch (
        .clock(clock),
        .rst(rst),
        .setBits(setVec[g]),
        .clearBits(clearVec[g]),
        .enable(sourceEnable[g]),
        .pending(pendingVec[g]),
        .request(sourceRequest[g])
      ); // [RULE_23]
    end
  end

  // fixed priority: the lowest source number wins
  always_comb begin
    pickFound = 1'b0;
    pickIndex = 5'h00;
    for (int i = NUM_SOURCES - 1; i >= 0; i--) begin
      if (sourceRequest[i]) begin
        pickFound = 1'b1;
        pickIndex = 5'(i);
      end
    end
    pickSource = ipr_source_t'(pickIndex);
  end

  // sequencer: present one report and hold it until acknowledged
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      IPR_SCAN: begin
        if (pickFound) begin
          state_d = IPR_HOLD;
        end
      end
      IPR_HOLD: begin
        if (reportAck) begin
          state_d = IPR_SCAN;
        end
      end
      default: begin
        state_d = IPR_SCAN;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= IPR_SCAN;
    end else begin
      state_q <= state_d;
    end
  end

  // capture identifier and cause word together so they always match
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sourceId_q <= ipr_source_t'(SOURCE_RESET);
      cause_q <= CAUSE_RESET;
    end else if (state_q == IPR_SCAN && pickFound) begin
      sourceId_q <= pickSource; // [RULE_01]
      cause_q <= pendingVec[pickIndex]; // [RULE_02]
    end
  end

  assign reportValid = (state_q == IPR_HOLD);
  assign sourceIdentifier = sourceId_q;
  assign causeWord = cause_q;
  // level request to the processor; stays up while anything enabled waits
  assign interruptRequest = |sourceRequest; // [RULE_23]

endmodule

// [ipr_cause_report_sva.sv]
`timescale 1ns/1ps
module ipr_cause_report_sva
  import ipr_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic clockSwitchEvent,
  input wire logic tickEvent,
  input wire logic [NUM_SOURCES-1:0] sourceEnable,
  input wire logic reportAck,
  input wire logic reportValid,
  input wire ipr_source_t sourceIdentifier,
  input wire logic [CAUSE_WIDTH-1:0] causeWord,
  input wire logic [NUM_SOURCES-1:0] sourceRequest,
  input wire logic interruptRequest
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  // a presented system report carrying the clock switch bit
  sequence sysClockReport;
    reportValid && sourceIdentifier == SYSTEM_CONTROLLER_SOURCE && causeWord[31];
  endsequence
  // a report that has just been serviced
  sequence ackTaken;
    reportValid && reportAck;
  endsequence
  // bound of 60 assumes the service answers within a few cycles
  AST_CLOCK_SWITCH:
  assert property (clockSwitchEvent && sourceEnable[0] |-> ##[1:60] sysClockReport)
    else $error("clock switch not reported");
  AST_IRQ_OR:
  assert property (interruptRequest == (|sourceRequest))
    else $error("summary request wrong");
  AST_TICK_REQ:
  assert property (tickEvent && sourceEnable[13] |=> sourceRequest[13] && interruptRequest)
    else $error("tick request missing");
  AST_HOLD:
  assert property (reportValid && !reportAck |=> reportValid && $stable(causeWord))
    else $error("report changed before service");
  AST_ACK:
  assert property (ackTaken |=> !reportValid)
    else $error("report kept after service");
  AST_TICK_CAUSE:
  assert property (reportValid && sourceIdentifier == TICK_TIMER_SOURCE |-> causeWord == 32'h1)
    else $error("tick cause not bit 0");
  AST_TIMER:
  assert property (reportValid && sourceIdentifier inside {[TIMER0_SOURCE:TIMER8_SOURCE]}
    |-> causeWord[31:2] == 30'h0 && causeWord[1:0] != 2'h0)
    else $error("timer cause bits wrong");
  AST_TWO_WIRE:
  assert property (reportValid && sourceIdentifier == TWO_WIRE_SOURCE
    |-> (causeWord & ~32'h0000_01cf) == 32'h0 && causeWord != 32'h0)
    else $error("two-wire cause bits wrong");
  AST_SERIAL:
  assert property (reportValid && sourceIdentifier == SERIAL_PORT0_SOURCE
    |-> causeWord[31:3] == 29'h0)
    else $error("serial cause not a code");
  AST_ADC:
  assert property (reportValid && sourceIdentifier == ANALOGUE_BLOCK_SOURCE
    |-> causeWord[31:5] == 27'h0 && causeWord[4:0] != 5'h0)
    else $error("analogue cause bits wrong");
endmodule

bind ipr_cause_report ipr_cause_report_sva u_ipr_cause_report_sva (.clock(clock), .rst(rst),
  .clockSwitchEvent(clockSwitchEvent), .tickEvent(tickEvent), .sourceEnable(sourceEnable),
  .reportAck(reportAck), .reportValid(reportValid), .sourceIdentifier(sourceIdentifier),
  .causeWord(causeWord), .sourceRequest(sourceRequest), .interruptRequest(interruptRequest));

// [ipr_cause_report_test.sv]
`timescale 1ns/1ps
module ipr_cause_report_test;
  import ipr_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [24:0] ev = '0;
  logic [19:0] io = '0;
  logic [19:0] enable = '1;
  logic [8:0] tOut = '0, tRise = '0, tFall = '0;
  logic [2:0] spCode = '0;
  logic accMode = 1'b0, masterMode = 1'b0, ack = 1'b0, spReq = 1'b0;
  logic reportValid, interruptRequest;
  ipr_source_t sourceIdentifier;
  logic [31:0] causeWord;
  logic [19:0] sourceRequest;
  int errors = 0, checked = 0;
  int i, k, m, n, t;

  always #4 clock = ~clock;

  // single-bit events share one vector so a table index can pulse any of them
  ipr_cause_report u_ipr_cause_report (
    .clock(clock), .rst(rst), .clockSwitchEvent(ev[0]), .randomValueEvent(ev[1]),
    .comparator1Event(ev[2]), .comparator0Event(ev[3]), .wakeTimer1Event(ev[4]),
    .wakeTimer0Event(ev[5]), .brownoutEnterEvent(ev[6]), .brownoutExitEvent(ev[7]),
    .pulseCounter1Event(ev[8]), .pulseCounter0Event(ev[9]), .ioLineEvent(io),
    .adcBufferOverflowEvent(ev[10]), .adcBufferFullEvent(ev[11]),
    .adcBufferHalfEvent(ev[12]), .adcAccumulatedReadyEvent(ev[13]),
    .adcSampleReadyEvent(ev[14]), .adcAccumulateMode(accMode), .timerOutput(tOut),
    .timerRisingIntEnable(tRise), .timerPeriodIntEnable(tFall), .tickEvent(ev[15]),
    .infraredDoneEvent(ev[16]), .twoWireMasterMode(masterMode),
    .masterTransferDone(ev[17]), .arbitrationLost(ev[18]), .masterNoAck(ev[19]),
    .slaveTxStopSeen(ev[20]), .twoWireBusError(ev[21]), .txDataRequest(ev[22]),
    .serialMasterEvents(32'h0), .serialSlaveEvents(32'h0), .flashErrorEvent(ev[23]),
    .cipherDoneEvent(ev[24]), .serialPort0Request(spReq), .serialPort0Code(spCode),
    .serialPort1Request(1'b0), .serialPort1Code(3'h0), .sourceEnable(enable),
    .reportAck(ack), .reportValid(reportValid), .sourceIdentifier(sourceIdentifier),
    .causeWord(causeWord), .sourceRequest(sourceRequest),
    .interruptRequest(interruptRequest));

  // expected source for table entry k
  function automatic logic [4:0] expId(input int k);
    if (k < 10) return 5'h00;
    if (k < 15) return 5'h01;
    case (k)
      15: return 5'h0d;
      16: return 5'h12;
      23: return 5'h11;
      24: return 5'h13;
      default: return 5'h0e;
    endcase
  endfunction

  // expected cause; m is the mode (master role, accumulation on)
  function automatic logic [31:0] expCause(input int k, input logic m);
    if (k == 13) return m ? 32'h0000_0002 : 32'h0;
    if (k < 10) return 32'h1 << (31 - k);
    if (k < 15) return 32'h1 << (14 - k);
    case (k)
      17: return m ? 32'h0000_0001 : 32'h0;
      18: return 32'h0000_0002;
      19: return m ? 32'h0000_0004 : 32'h0;
      20: return m ? 32'h0 : 32'h0000_0008;
      21: return 32'h0000_0040;
      22: return m ? 32'h0000_0080 : 32'h0000_0100;
      default: return 32'h0000_0001;
    endcase
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one-cycle event pulse with the role and mode set for that cycle
  task fire(input int k, input logic m);
    @(posedge clock);
    masterMode <= m;
    accMode <= m;
    ev[k] <= 1'b1;
    @(posedge clock) ev[k] <= 1'b0;
  endtask

  // serve every report of one source; a split snapshot is merged before comparing
  task collect(input logic [4:0] id, input logic [31:0] exp);
    logic [31:0] acc;
    int w;
    logic served;
    acc = '0;
    w = 0;
    served = 1'b0;
    while (w < 6) begin
      @(posedge clock);
      #1;
      if (reportValid === 1'b1 && served && sourceIdentifier !== ipr_source_t'(id)) begin
        // another source queued behind this one; its own collect serves it
        w = 6;
      end else if (reportValid === 1'b1) begin
        check({27'h0, sourceIdentifier}, {27'h0, id});
        served = 1'b1;
        acc = acc | causeWord;
        @(posedge clock) ack <= 1'b1;
        @(posedge clock) ack <= 1'b0;
        w = 0;
      end else begin
        w++;
      end
    end
    check(acc, exp);
  endtask

  task give_verdict();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // hang guard, well past the few thousand cycles the tests need
  initial begin
    #400000;
    errors++;
    give_verdict();
  end

  initial begin
    n = $urandom(83);
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    // every event in both roles; refused role and mode causes give nothing
    for (m = 0; m < 2; m++) begin
      for (k = 0; k < 25; k++) begin
        fire(k, m[0]);
        collect(expId(k), expCause(k, m[0]));
      end
    end
    $display("event table test done");
    for (i = 0; i < 40; i++) begin
      k = $urandom_range(24, 0);
      fire(k, 1'($urandom));
      collect(expId(k), expCause(k, masterMode));
      n = $urandom_range(19, 0);
      @(posedge clock) io[n] <= 1'b1;
      @(posedge clock) io <= '0;
      collect(5'h00, 32'h1 << n);
    end
    $display("random event test done");
    // a disabled source keeps its cause and reports once enabled
    @(posedge clock) enable <= 20'hffffe;
    fire(6, 1'b0);
    repeat (3) @(posedge clock);
    #1;
    check({31'h0, interruptRequest}, 32'h0);
    @(posedge clock) enable <= '1;
    collect(5'h00, 32'h0200_0000);
    // simultaneous tick and system events, then another back to back
    @(posedge clock);
    ev[15] <= 1'b1;
    ev[1] <= 1'b1;
    @(posedge clock) ev <= 25'h1;
    @(posedge clock) ev <= '0;
    collect(5'h00, 32'hc000_0000);
    collect(5'h0d, 32'h1);
    $display("priority test done");
    // each timer: enabled rise, enabled fall, then rise with its enable off
    for (t = 0; t < 9; t++) begin
      @(posedge clock);
      tRise <= '1;
      tFall <= '1;
      tOut[t] <= 1'b1;
      collect(5'(t + 4), 32'h2);
      @(posedge clock) tOut <= '0;
      collect(5'(t + 4), 32'h1);
      @(posedge clock);
      tRise <= '0;
      tOut[t] <= 1'b1;
      collect(5'(t + 4), 32'h0);
      @(posedge clock) tOut <= '0;
      collect(5'(t + 4), 32'h1);
    end
    $display("timer test done");
    // serial port reason code; the port withdraws its request when served
    for (i = 0; i < 6; i++) begin
      @(posedge clock);
      spCode <= 3'($urandom);
      spReq <= 1'b1;
      n = 0;
      do begin
        @(posedge clock);
        #1;
        n++;
      end while (reportValid !== 1'b1 && n < 10);
      check({27'h0, sourceIdentifier}, 32'h2);
      check(causeWord, {29'h0, spCode});
      @(posedge clock);
      ack <= 1'b1;
      spReq <= 1'b0;
      @(posedge clock) ack <= 1'b0;
      collect(5'h02, 32'h0);
    end
    $display("serial code test done");
    give_verdict();
  end
endmodule
